// ### hdl/gpp_port.sv
/*
  gpp_port: two general purpose I/O ports (first port 8 bits with
  falling-edge wake-up, second port 5 bits) behind data memory.
  Assumes the core issues one-cycle read/write strobes on its data
  memory bus, that pin-mux logic elsewhere reports which pins are GPIO
  and which are NMOS open-drain outputs, and that the pad ring resolves
  drive, output enable and pull-up into the real pin level.
*/
`timescale 1ns/1ps
`default_nettype none

module gpp_port
  import gpp_pkg::*;
#(
  parameter int A_W = gpp_pkg::FIRST_PORT_W,
  parameter int B_W = gpp_pkg::SECOND_PORT_W
) (
  // clock and reset
  input  wire logic                       mclk,
  input  wire logic                       rst_n,
  // data memory bus from the core
  input  wire logic [gpp_pkg::ADDR_W-1:0] memAddr,
  input  wire logic                       memWrEn,
  input  wire logic [gpp_pkg::DATA_W-1:0] memWrData,
  input  wire logic                       memRdEn,
  output logic      [gpp_pkg::DATA_W-1:0] memRdData,
  // core power state and pin-mux status
  input  wire logic                       coreSleep,
  input  wire logic [A_W-1:0]             firstPortGpioSel,
  input  wire logic [A_W-1:0]             firstPortNmosOd,
  input  wire logic [B_W-1:0]             secondPortNmosOd,
  // first port pins
  input  wire logic [A_W-1:0]             firstPortIn,
  output logic      [A_W-1:0]             firstPortOut,
  output logic      [A_W-1:0]             firstPortOe,
  output logic      [A_W-1:0]             firstPortPullupEn,
  // second port pins
  input  wire logic [B_W-1:0]             secondPortIn,
  output logic      [B_W-1:0]             secondPortOut,
  output logic      [B_W-1:0]             secondPortOe,
  output logic      [B_W-1:0]             secondPortPullupEn,
  // wake-up request to the power controller
  output logic                            wakeReq
);
  import gpp_pkg::*;

  typedef struct packed {
    logic [A_W-1:0]    aData;
    logic [A_W-1:0]    aDir;
    logic [A_W-1:0]    aPull;
    logic [A_W-1:0]    aWake;
    logic [B_W-1:0]    bData;
    logic [B_W-1:0]    bDir;
    logic [B_W-1:0]    bPull;
    logic [A_W-1:0]    aPrev;
    logic              wake;
    logic [DATA_W-1:0] rdData;
  } gpp_state_t;

  gpp_state_t state_r;
  gpp_state_t state_nxt;

  logic [A_W-1:0] aSync;
  logic [A_W-1:0] aFall;
  logic [A_W-1:0] aWakeArmed;

  // read value of one port: live pin for inputs, latch for outputs
  function automatic logic [DATA_W-1:0] port_view(
    input logic [DATA_W-1:0] latchVal,
    input logic [DATA_W-1:0] dirVal,
    input logic [DATA_W-1:0] pinVal
  );
    port_view = (dirVal & pinVal) | (~dirVal & latchVal);
  endfunction

  // zero-extend a narrower register to a byte for reads
  function automatic logic [DATA_W-1:0] zext_a(input logic [A_W-1:0] v);
    zext_a = DATA_W'(v);
  endfunction

  function automatic logic [DATA_W-1:0] zext_b(input logic [B_W-1:0] v);
    zext_b = DATA_W'(v);
  endfunction

  // first port levels cross into the clock domain before edge detection
  gpp_sync #(
    .WIDTH (A_W)
  ) u_sync_a (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .asyncIn (firstPortIn),
    .syncOut (aSync)
  );

  // a pin may wake the core only as a GPIO input during sleep
  assign aWakeArmed = state_r.aWake & firstPortGpioSel & state_r.aDir
                    & {A_W{coreSleep}};
  assign aFall      = state_r.aPrev & ~aSync;

  always_comb begin
    state_nxt       = state_r;
    state_nxt.aPrev = aSync;
    state_nxt.wake  = |(aFall & aWakeArmed);

    if (memWrEn) begin
      unique case (memAddr)
        ADDR_FIRST_PORT: begin
          state_nxt.aData = memWrData[A_W-1:0];
        end
        ADDR_FIRST_PORT_DIRECTION: begin
          state_nxt.aDir = memWrData[A_W-1:0];
        end
        ADDR_FIRST_PORT_PULLUP: begin
          state_nxt.aPull = memWrData[A_W-1:0];
        end
        ADDR_FIRST_PORT_WAKE_ENABLE: begin
          state_nxt.aWake = memWrData[A_W-1:0];
        end
        ADDR_SECOND_PORT: begin
          state_nxt.bData = memWrData[B_W-1:0];
        end
        ADDR_SECOND_PORT_DIRECTION: begin
          state_nxt.bDir = memWrData[B_W-1:0];
        end
        ADDR_SECOND_PORT_PULLUP: begin
          state_nxt.bPull = memWrData[B_W-1:0];
        end
        default: begin
        end
      endcase
    end

    if (memRdEn) begin
      unique case (memAddr)
        ADDR_FIRST_PORT: begin
          state_nxt.rdData = port_view(zext_a(state_r.aData), zext_a(state_r.aDir),
                                       zext_a(firstPortIn));
        end
        ADDR_FIRST_PORT_DIRECTION: begin
          state_nxt.rdData = zext_a(state_r.aDir);
        end
        ADDR_FIRST_PORT_PULLUP: begin
          state_nxt.rdData = zext_a(state_r.aPull);
        end
        ADDR_FIRST_PORT_WAKE_ENABLE: begin
          state_nxt.rdData = zext_a(state_r.aWake);
        end
        ADDR_SECOND_PORT: begin
          state_nxt.rdData = port_view(zext_b(state_r.bData), zext_b(state_r.bDir),
                                       zext_b(secondPortIn));
        end
        ADDR_SECOND_PORT_DIRECTION: begin
          state_nxt.rdData = zext_b(state_r.bDir);
        end
        ADDR_SECOND_PORT_PULLUP: begin
          state_nxt.rdData = zext_b(state_r.bPull);
        end
        default: begin
          state_nxt.rdData = RD_UNMAPPED;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_r.aData  <= RST_PORT_DATA[A_W-1:0];
      state_r.aDir   <= RST_PORT_DIR[A_W-1:0];
      state_r.aPull  <= RST_PORT_PULLUP[A_W-1:0];
      state_r.aWake  <= RST_PORT_WAKE[A_W-1:0];
      state_r.bData  <= RST_PORT_DATA[B_W-1:0];
      state_r.bDir   <= RST_PORT_DIR[B_W-1:0];
      state_r.bPull  <= RST_PORT_PULLUP[B_W-1:0];
      state_r.aPrev  <= '0;
      state_r.wake   <= 1'b0;
      state_r.rdData <= RD_UNMAPPED;
    end else begin
      state_r <= state_nxt;
    end
  end

  // per-pin drive: push-pull outputs drive both levels, open-drain only low
  genvar gi;
  generate
    for (gi = 0; gi < A_W; gi++) begin : g_pin_a
      always_comb begin
        firstPortOut[gi] = state_r.aData[gi];
        firstPortOe[gi]  = firstPortNmosOd[gi] ? ~state_r.aData[gi]
                                              : ~state_r.aDir[gi];
        firstPortPullupEn[gi] = state_r.aPull[gi]
                              & (state_r.aDir[gi] | firstPortNmosOd[gi]);
      end
    end
    for (gi = 0; gi < B_W; gi++) begin : g_pin_b
      always_comb begin
        secondPortOut[gi] = state_r.bData[gi];
        secondPortOe[gi]  = secondPortNmosOd[gi] ? ~state_r.bData[gi]
                                                : ~state_r.bDir[gi];
        secondPortPullupEn[gi] = state_r.bPull[gi]
                               & (state_r.bDir[gi] | secondPortNmosOd[gi]);
      end
    end
  endgenerate

  assign memRdData = state_r.rdData;
  assign wakeReq   = state_r.wake;

endmodule

`default_nettype wire

// ### common/gpp_pkg.sv
/*
  gpp_pkg: constants for the two-port general purpose I/O block.
  Assumes an 8-bit data memory bus from the core; register addresses
  are fixed data memory locations inside the special purpose area.
*/
package gpp_pkg;

  // widths
  localparam int FIRST_PORT_W  = 8;
  localparam int SECOND_PORT_W = 5;
  localparam int DATA_W        = 8;
  localparam int ADDR_W        = 8;

  // data memory addresses
  localparam logic [ADDR_W-1:0] ADDR_FIRST_PORT             = 8'h14;
  localparam logic [ADDR_W-1:0] ADDR_FIRST_PORT_DIRECTION   = 8'h15;
  localparam logic [ADDR_W-1:0] ADDR_FIRST_PORT_PULLUP      = 8'h16;
  localparam logic [ADDR_W-1:0] ADDR_FIRST_PORT_WAKE_ENABLE = 8'h17;
  localparam logic [ADDR_W-1:0] ADDR_SECOND_PORT            = 8'h18;
  localparam logic [ADDR_W-1:0] ADDR_SECOND_PORT_DIRECTION  = 8'h19;
  localparam logic [ADDR_W-1:0] ADDR_SECOND_PORT_PULLUP     = 8'h1a;

  // values after reset
  localparam logic [DATA_W-1:0] RST_PORT_DATA   = 8'hff;
  localparam logic [DATA_W-1:0] RST_PORT_DIR    = 8'hff;
  localparam logic [DATA_W-1:0] RST_PORT_PULLUP = 8'h00;
  localparam logic [DATA_W-1:0] RST_PORT_WAKE   = 8'h00;
  localparam logic [DATA_W-1:0] RD_UNMAPPED     = 8'h00;

  // synchroniser depth
  localparam int SYNC_STAGES = 2;

endpackage

// ### hdl/gpp_sync.sv
/*
  gpp_sync: multi-bit two flip-flop level synchroniser for pin inputs.
  Assumes each bit is an independent level; no word coherence is given.
*/
`timescale 1ns/1ps
`default_nettype none

module gpp_sync #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             rst_n,
  // levels
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);
  import gpp_pkg::*;

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } gpp_sync_t;

  gpp_sync_t state_r;
  gpp_sync_t state_nxt;

  always_comb begin
    state_nxt        = state_r;
    state_nxt.meta   = asyncIn;
    // first stage feeds only the second stage
    state_nxt.stable = state_r.meta;
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign syncOut = state_r.stable;

endmodule

`default_nettype wire

// ### sim/gpp_switches.sv
/* gpp_switches: external switches on the pins of one port.
   Assumes pad controls from gpp_port; an open pin with no pull-up flickers. */
`timescale 1ns/1ps
`default_nettype none
module gpp_switches #(
  parameter int W = 8
) (
  // clock
  input  wire logic         mclk,
  // pad controls
  input  wire logic [W-1:0] oe,
  input  wire logic [W-1:0] out,
  input  wire logic [W-1:0] pu,
  // switch contacts
  input  wire logic [W-1:0] swOn,
  input  wire logic [W-1:0] swLvl,
  // resolved pins
  output logic      [W-1:0] pin
);
  logic [W-1:0] lastPin_r;
  always_ff @(posedge mclk) lastPin_r <= pin;
  always_comb begin
    for (int i = 0; i < W; i++) begin
      if (oe[i]) pin[i] = out[i];
      else if (swOn[i]) pin[i] = swLvl[i];
      else if (pu[i]) pin[i] = 1'b1;
      else pin[i] = ~lastPin_r[i];
    end
  end
endmodule
`default_nettype wire

// ### sim/gpp_port_monitor.sv
/* gpp_port_monitor: port-level checks of gpp_port.
   Assumes gpp_pkg; bound to every gpp_port instance. */
`timescale 1ns/1ps
`default_nettype none
module gpp_port_monitor
  import gpp_pkg::*;
#(
  parameter int A_W = 8,
  parameter int B_W = 5
) (
  // clock and reset
  input wire logic           mclk,
  input wire logic           rst_n,
  // bus and state
  input wire logic [7:0]     memAddr,
  input wire logic           memWrEn,
  input wire logic [7:0]     memWrData,
  input wire logic           coreSleep,
  // pins
  input wire logic [A_W-1:0] firstPortNmosOd,
  input wire logic [A_W-1:0] firstPortIn,
  input wire logic [A_W-1:0] firstPortOut,
  input wire logic [A_W-1:0] firstPortOe,
  input wire logic [A_W-1:0] firstPortPullupEn,
  input wire logic [B_W-1:0] secondPortOut,
  input wire logic [B_W-1:0] secondPortOe,
  input wire logic           wakeReq
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_write_latch: assert property (memWrEn && memAddr == ADDR_FIRST_PORT
    |=> firstPortOut == $past(memWrData[A_W-1:0])) else $error("latch not loaded");
  a_latch_hold: assert property ($past(rst_n) && !($past(memWrEn)
    && $past(memAddr) == ADDR_FIRST_PORT) |-> $stable(firstPortOut)) else $error("latch moved");
  a_second_write: assert property (memWrEn && memAddr == ADDR_SECOND_PORT
    |=> secondPortOut == $past(memWrData[B_W-1:0])) else $error("port b latch wrong");
  a_pullup_gate: assert property ((firstPortPullupEn & firstPortOe
    & ~firstPortNmosOd) == '0) else $error("pull-up on a driven output");
  a_od_drive: assert property (((firstPortOe ^ ~firstPortOut)
    & firstPortNmosOd) == '0) else $error("open-drain drive wrong");
  a_reset_inputs: assert property ($rose(rst_n) |-> firstPortOe == '0
    && secondPortOe == '0 && !wakeReq) else $error("pins not inputs after reset");
  a_wake_pulse: assert property (wakeReq |=> !wakeReq
    || |($past(firstPortIn, 4) & ~$past(firstPortIn, 3))) else $error("wake too long");
  a_wake_cause: assert property (wakeReq |->
    |($past(firstPortIn, 4) & ~$past(firstPortIn, 3))) else $error("wake without a pin fall");
  a_wake_sleep: assert property (wakeReq |-> $past(coreSleep)) else $error("wake awake");
  c_wake: cover property (wakeReq);
  c_write: cover property (memWrEn && memAddr == ADDR_FIRST_PORT);
  c_od: cover property (|(firstPortNmosOd & firstPortPullupEn));
endmodule
bind gpp_port gpp_port_monitor #(.A_W(A_W), .B_W(B_W)) mon_u (.mclk(mclk), .rst_n(rst_n),
  .memAddr(memAddr), .memWrEn(memWrEn), .memWrData(memWrData), .coreSleep(coreSleep),
  .firstPortNmosOd(firstPortNmosOd), .firstPortIn(firstPortIn),
  .firstPortOut(firstPortOut), .firstPortOe(firstPortOe),
  .firstPortPullupEn(firstPortPullupEn), .secondPortOut(secondPortOut),
  .secondPortOe(secondPortOe), .wakeReq(wakeReq));
`default_nettype wire

// ### sim/gpp_port_bench.sv
/* gpp_port_bench: directed test of gpp_port with switches on its pins.
   Assumes gpp_pkg, gpp_switches and the bound monitor. */
`timescale 1ns/1ps
`default_nettype none
module gpp_port_bench;
  import gpp_pkg::*;
  logic       mclk = 0, rst_n = 0, memWrEn = 0, memRdEn = 0, coreSleep = 0, wakeReq;
  logic [7:0] memAddr = 8'h00, memWrData = 8'h00, memRdData, swOnA = 8'hff;
  logic [7:0] firstPortGpioSel = 8'hff, firstPortNmosOd = 8'h00, swLvlA = 8'ha5;
  logic [7:0] pinA, outA, oeA, puA;
  logic [4:0] secondPortNmosOd = 5'h00, pinB, outB, oeB, puB;
  int         nErrors = 0, comparisons = 0, cycles = 0;
  always #5 mclk = ~mclk;
  gpp_port dut_u (.mclk(mclk), .rst_n(rst_n), .memAddr(memAddr), .memWrEn(memWrEn),
    .memWrData(memWrData), .memRdEn(memRdEn), .memRdData(memRdData), .coreSleep(coreSleep),
    .firstPortGpioSel(firstPortGpioSel), .firstPortNmosOd(firstPortNmosOd),
    .secondPortNmosOd(secondPortNmosOd), .firstPortIn(pinA), .firstPortOut(outA),
    .firstPortOe(oeA), .firstPortPullupEn(puA), .secondPortIn(pinB), .secondPortOut(outB),
    .secondPortOe(oeB), .secondPortPullupEn(puB), .wakeReq(wakeReq));
  gpp_switches #(.W(8)) swA_u (.mclk(mclk), .oe(oeA), .out(outA), .pu(puA), .swOn(swOnA),
    .swLvl(swLvlA), .pin(pinA));
  gpp_switches #(.W(5)) swB_u (.mclk(mclk), .oe(oeB), .out(outB), .pu(puB), .swOn(5'h1f),
    .swLvl(5'h0a), .pin(pinB));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      nErrors++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    memWrEn <= 1'b1;
    memAddr <= a;
    memWrData <= d;
    @(posedge mclk);
    memWrEn <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk);
    memRdEn <= 1'b1;
    memAddr <= a;
    @(posedge mclk);
    memRdEn <= 1'b0;
    #1;
    chk(memRdData, exp);
  endtask
  task automatic quiet(input int n);
    repeat (n) begin
      @(posedge mclk);
      #1;
      chk({7'h00, wakeReq}, 8'h00);
    end
  endtask
  task automatic no_wake(input logic s, input logic [7:0] g);
    @(posedge mclk);
    swLvlA <= 8'hff;
    coreSleep <= s;
    firstPortGpioSel <= g;
    quiet(4);
    @(posedge mclk);
    swLvlA <= 8'hfb;
    quiet(6);
  endtask
  task automatic t_reset;
    chk(oeA, 8'h00);
    rd(ADDR_FIRST_PORT, 8'ha5);
    rd(ADDR_FIRST_PORT_DIRECTION, 8'hff);
    rd(ADDR_FIRST_PORT_PULLUP, 8'h00);
    rd(ADDR_FIRST_PORT_WAKE_ENABLE, 8'h00);
    rd(ADDR_SECOND_PORT, 8'h0a);
    rd(ADDR_SECOND_PORT_DIRECTION, 8'h1f);
    rd(8'h00, 8'h00);
    @(posedge mclk);
    swLvlA <= 8'h00;
    rd(ADDR_FIRST_PORT, 8'h00);
  endtask
  task automatic t_latch;
    @(posedge mclk);
    firstPortNmosOd <= 8'h01;
    wr(ADDR_FIRST_PORT_DIRECTION, 8'h00);
    wr(ADDR_FIRST_PORT, 8'h3d);
    chk(oeA, 8'hfe);
    rd(ADDR_FIRST_PORT, 8'h3d);
    wr(ADDR_FIRST_PORT_PULLUP, 8'hff);
    chk(puA, 8'h01);
    @(posedge mclk);
    swOnA <= 8'h7f;
    wr(ADDR_FIRST_PORT_DIRECTION, 8'hf0);
    chk(puA, 8'hf1);
    chk(outA, 8'h3d);
    rd(ADDR_FIRST_PORT, 8'h8d);
    wr(ADDR_SECOND_PORT_DIRECTION, 8'h00);
    wr(ADDR_SECOND_PORT, 8'hff);
    rd(ADDR_SECOND_PORT, 8'h1f);
    chk({3'h0, oeB}, 8'h1f);
    wr(ADDR_SECOND_PORT_PULLUP, 8'h1f);
    chk({3'h0, puB}, 8'h00);
    @(posedge mclk);
    secondPortNmosOd <= 5'h01;
    #1;
    chk({3'h0, puB}, 8'h01);
    chk({3'h0, oeB}, 8'h1e);
  endtask
  task automatic t_wake;
    int n;
    wr(ADDR_FIRST_PORT_DIRECTION, 8'hff);
    wr(ADDR_FIRST_PORT_WAKE_ENABLE, 8'h04);
    @(posedge mclk);
    swLvlA <= 8'hff;
    coreSleep <= 1'b1;
    firstPortGpioSel <= 8'hff;
    quiet(4);
    @(posedge mclk);
    swLvlA <= 8'hfb;
    n = 0;
    do begin
      @(posedge mclk);
      #1;
      n++;
    end while (wakeReq !== 1'b1 && n < 8);
    chk(8'(n), 8'h03);
    quiet(4);
    @(posedge mclk);
    swLvlA <= 8'hf3;
    quiet(6);
    no_wake(1'b0, 8'hff);
    no_wake(1'b1, 8'hfb);
  endtask
  task automatic tally_and_finish;
    if (nErrors == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      nErrors++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    t_reset();
    t_latch();
    t_wake();
    tally_and_finish();
  end
endmodule
`default_nettype wire
